/* hw/brtc_top.sv */
// backup-domain bcd calendar clock with apb register access
//
// Summary of operation
// - prescaler divides source, one second per wrap
// - source select: watch crystal or alternate
// - terminal counts 32768, 60 or 50
// - trim applies only at 32768 setting
// - six-bit trim, 128 ticks per unit
// - trim direction: add shortens, subtract lengthens
// - only cold start or soft bit resets
// - fields stored bcd except month, which is binary 1 to 12; constant bits dropped
// - seconds and minutes count 0 to 59
// - hours 0-23, or 1-12 with pm bit
// - hour format bit: 1 twelve, 0 twentyfour
// - weekday counts 1 to 7
// - date 1-31, month 1-12, year 0-99
// - february 29 days when year divisible four
// - century event on year 99 to 00
// - read request freezes live copy in user
// - read request refused while busy or writing
// - user writes only accepted during write request
// - write release loads all fields together
// - write request refused while busy or reading
`timescale 1ns/1ps
`include "brtc_map.svh"
module brtc_top (
  // clock, cold-start reset, enable
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // low-frequency sources, sampled on sys_clk
  input  wire logic        watch_crystal_osc,
  input  wire logic        low_freq_system_clock,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator control and status
  output logic             watch_osc_enable,
  output logic             osc_bypass_select,
  output logic             rtc_busy,
  output logic             century_event
);
  import brtc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state
  brtc_st_t s_q;
  brtc_st_t s_d;

  // resetn is the backup supply loss only; system resets never reach here
  localparam brtc_st_t RST = '{
    pre:  BRTC_PRE_32K,
    hs:   BRTC_IDLE,
    live: '{day_of_month: `BRTC_RST_DATE, month_field: `BRTC_RST_MON,
            weekday: `BRTC_RST_DAY, default: '0},
    user: '{day_of_month: `BRTC_RST_DATE, month_field: `BRTC_RST_MON,
            weekday: `BRTC_RST_DAY, default: '0},
    default: '0
  };

  //////////////////////////////////////////////////////////////////////
  // timebase
  logic        lf_in;
  logic        lf_rise;
  logic        hour_end;
  logic [15:0] trim_ticks;
  logic [15:0] term;
  logic        tick;
  logic        load;

  // stopped oscillator gives no edges, so a missing crystal freezes time
  assign lf_in      = s_q.src ? low_freq_system_clock
                              : (watch_crystal_osc & s_q.osc_en);
  assign lf_rise    = lf_in & ~s_q.lf_prev;
  // the trim lands on the last second of each hour
  assign hour_end   = (s_q.live.minutes == 7'h59) && (s_q.live.seconds_field == 7'h59);
  assign trim_ticks = {3'h0, s_q.trim_magnitude, 7'h00} ;

  always_comb begin
    case (s_q.pre)
      BRTC_PRE_60: term = `BRTC_TERM_60;
      BRTC_PRE_50: term = `BRTC_TERM_50;
      default: begin
        term = `BRTC_TERM_32K;
        if (hour_end && s_q.trim_magnitude != 6'h00) begin
          term = s_q.trim_direction ? `BRTC_TERM_32K - trim_ticks
                                    : `BRTC_TERM_32K + trim_ticks;
        end
      end
    endcase
  end

  assign load = (s_q.hs == BRTC_WLOAD) && lf_rise;
  assign tick = lf_rise && (s_q.div >= term - 16'h0001) && !load;

  //////////////////////////////////////////////////////////////////////
  // calendar advance
  logic [6:0] n_sec;
  logic [6:0] n_min;
  logic [5:0] n_hour;
  logic [2:0] n_day;
  logic [5:0] n_date;
  logic [3:0] n_mon;
  logic [7:0] n_year;
  logic       n_cent;

  brtc_cal_step u_step (
    .sec                (s_q.live.seconds_field),
    .min                (s_q.live.minutes),
    .hour               (s_q.live.hours),
    .hour_format_select (s_q.live.hour_format_select),
    .day                (s_q.live.weekday),
    .date               (s_q.live.day_of_month),
    .month_field        (s_q.live.month_field),
    .year               (s_q.live.year),
    .sec_n              (n_sec),
    .min_n              (n_min),
    .hour_n             (n_hour),
    .day_n              (n_day),
    .date_n             (n_date),
    .mon_n              (n_mon),
    .year_n             (n_year),
    .century            (n_cent)
  );

  //////////////////////////////////////////////////////////////////////
  // bus decode
  logic        setup;
  logic        acc_wr;
  logic        mapped;
  logic        soft_rst;
  logic        wr_rw;
  logic [31:0] rd_mux;

  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `BRTC_OFF_DATE);
  assign wr_rw  = acc_wr && (paddr == `BRTC_OFF_RW);
  assign soft_rst = acc_wr && (paddr == `BRTC_OFF_RESET) && pwdata[`BRTC_RST_BIT];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `BRTC_OFF_CTRL: begin
        rd_mux[`BRTC_CTRL_OSC] = s_q.osc_en;
        rd_mux[`BRTC_CTRL_BYP] = s_q.bypass;
        rd_mux[`BRTC_CTRL_SRC] = s_q.src;
        rd_mux[`BRTC_CTRL_PRE +: 2] = s_q.pre;
      end
      `BRTC_OFF_TRIM: begin
        rd_mux[5:0] = s_q.trim_magnitude;
        rd_mux[`BRTC_TRIM_DIR] = s_q.trim_direction;
      end
      `BRTC_OFF_RW: begin
        rd_mux[`BRTC_RW_RD] = (s_q.hs == BRTC_RCOPY) || (s_q.hs == BRTC_RHOLD);
        rd_mux[`BRTC_RW_WR] = (s_q.hs == BRTC_WOPEN);
      end
      `BRTC_OFF_STAT: begin
        rd_mux[`BRTC_STAT_BUSY] = rtc_busy;
        rd_mux[`BRTC_STAT_CENT] = s_q.cent;
      end
      `BRTC_OFF_TIME: begin
        rd_mux[`BRTC_SEC_LSB +: 7]  = s_q.user.seconds_field;
        rd_mux[`BRTC_MIN_LSB +: 7]  = s_q.user.minutes;
        rd_mux[`BRTC_HOUR_LSB +: 6] = s_q.user.hours;
        rd_mux[`BRTC_FMT_BIT]       = s_q.user.hour_format_select;
        rd_mux[`BRTC_DAY_LSB +: 3]  = s_q.user.weekday;
      end
      `BRTC_OFF_DATE: begin
        rd_mux[`BRTC_DATE_LSB +: 6] = s_q.user.day_of_month;
        rd_mux[`BRTC_MON_LSB +: 4]  = s_q.user.month_field;
        rd_mux[`BRTC_YEAR_LSB +: 8] = s_q.user.year;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.lf_prev    = lf_in;
    s_d.cent_pulse = 1'b0;
    // apb: answer is prepared in setup, pready high through access
    if (setup) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !mapped;
      s_d.prdata  = mapped ? rd_mux : 32'h0000_0000;
    end else if (psel && penable && s_q.pready) begin
      s_d.pready = 1'b0;
    end
    if (acc_wr) begin
      case (paddr)
        `BRTC_OFF_CTRL: begin
          s_d.osc_en = pwdata[`BRTC_CTRL_OSC];
          s_d.bypass = pwdata[`BRTC_CTRL_BYP];
          s_d.src    = pwdata[`BRTC_CTRL_SRC];
          s_d.pre    = brtc_pre_t'(pwdata[`BRTC_CTRL_PRE +: 2]);
        end
        `BRTC_OFF_TRIM: begin
          s_d.trim_magnitude = pwdata[5:0];
          s_d.trim_direction = pwdata[`BRTC_TRIM_DIR];
        end
        `BRTC_OFF_STAT: begin
          if (pwdata[`BRTC_STAT_CENT]) s_d.cent = 1'b0;
        end
        `BRTC_OFF_TIME: begin
          if (s_q.hs == BRTC_WOPEN) begin
            s_d.user.seconds_field      = pwdata[`BRTC_SEC_LSB +: 7];
            s_d.user.minutes            = pwdata[`BRTC_MIN_LSB +: 7];
            s_d.user.hours              = pwdata[`BRTC_HOUR_LSB +: 6];
            s_d.user.hour_format_select = pwdata[`BRTC_FMT_BIT];
            s_d.user.weekday            = pwdata[`BRTC_DAY_LSB +: 3];
          end
        end
        `BRTC_OFF_DATE: begin
          if (s_q.hs == BRTC_WOPEN) begin
            s_d.user.day_of_month = pwdata[`BRTC_DATE_LSB +: 6];
            s_d.user.month_field  = pwdata[`BRTC_MON_LSB +: 4];
            s_d.user.year         = pwdata[`BRTC_YEAR_LSB +: 8];
          end
        end
        default: ;
      endcase
    end
    // read/write handshake
    case (s_q.hs)
      BRTC_IDLE: begin
        if (wr_rw && pwdata[`BRTC_RW_RD] && !pwdata[`BRTC_RW_WR]) begin
          s_d.hs   = BRTC_RCOPY;
          s_d.user = s_q.live;
        end else if (wr_rw && pwdata[`BRTC_RW_WR] && !pwdata[`BRTC_RW_RD]) begin
          s_d.hs = BRTC_WOPEN;
        end
      end
      BRTC_WOPEN: begin
        // read set refused while write is open
        if (wr_rw && !pwdata[`BRTC_RW_WR]) s_d.hs = BRTC_WLOAD;
      end
      BRTC_WLOAD: begin
        // both requests refused until the low-frequency edge loads
        if (load) s_d.hs = BRTC_IDLE;
      end
      BRTC_RCOPY, BRTC_RHOLD: begin
        // user copy stays frozen; write set refused meanwhile
        if (wr_rw && !pwdata[`BRTC_RW_RD]) s_d.hs = BRTC_IDLE;
        else s_d.hs = BRTC_RHOLD;
      end
      default: s_d.hs = BRTC_IDLE;
    endcase
    // timebase and calendar
    if (load) begin
      s_d.live = s_q.user;
    end else if (lf_rise) begin
      s_d.div = s_q.div + 16'h0001;
      if (tick) begin
        s_d.div = 16'h0000;
        s_d.live.seconds_field = n_sec;
        s_d.live.minutes       = n_min;
        s_d.live.hours         = n_hour;
        s_d.live.weekday       = n_day;
        s_d.live.day_of_month  = n_date;
        s_d.live.month_field   = n_mon;
        s_d.live.year          = n_year;
        if (n_cent) begin
          s_d.cent       = 1'b1;
          s_d.cent_pulse = 1'b1;
        end
      end
    end
    if (soft_rst) begin
      s_d = RST;
      s_d.lf_prev = lf_in;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = s_q.pslverr;
  assign watch_osc_enable  = s_q.osc_en;
  assign osc_bypass_select = s_q.bypass;
  assign rtc_busy          = (s_q.hs == BRTC_RCOPY) || (s_q.hs == BRTC_WLOAD);
  assign century_event     = s_q.cent_pulse;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_TICK_WRAP: assert property (clk_en && tick && !soft_rst |=> s_q.div == 16'h0000)
    else $error("prescaler did not wrap on tick");
  AST_SRC_STOP: assert property (clk_en && !s_q.src && !s_q.osc_en && !soft_rst
      && !(s_q.hs == BRTC_WLOAD) |=> $stable(s_q.div) && $stable(s_q.live))
    else $error("calendar moved with crystal disabled");
  AST_TERM_MAINS: assert property (s_q.pre == BRTC_PRE_60 |-> term == 16'h003c)
    else $error("wrong terminal count for 60 Hz");
  AST_TRIM_IGNORED: assert property (s_q.pre == BRTC_PRE_50 |-> term == 16'h0032)
    else $error("trim leaked into 50 Hz count");
  AST_TRIM_ADD: assert property (s_q.pre == BRTC_PRE_32K && hour_end && s_q.trim_direction
      |-> term == 16'h8000 - {3'h0, s_q.trim_magnitude, 7'h00})
    else $error("added trim gives wrong count");
  AST_TRIM_SUB: assert property (s_q.pre == BRTC_PRE_32K && hour_end && !s_q.trim_direction
      |-> term == 16'h8000 + {3'h0, s_q.trim_magnitude, 7'h00})
    else $error("subtracted trim gives wrong count");
  AST_RD_REFUSE: assert property (clk_en && s_q.hs == BRTC_WOPEN && wr_rw && !soft_rst
      |=> s_q.hs != BRTC_RCOPY && s_q.hs != BRTC_RHOLD)
    else $error("read request taken while writing");
  AST_WR_REFUSE: assert property (clk_en && s_q.hs inside {BRTC_RCOPY, BRTC_RHOLD, BRTC_WLOAD}
      && wr_rw |=> s_q.hs != BRTC_WOPEN)
    else $error("write request taken while busy or reading");
  AST_USER_LOCK: assert property (clk_en && acc_wr && s_q.hs != BRTC_WOPEN && !wr_rw
      && !soft_rst |=> $stable(s_q.user))
    else $error("user field written without write request");
  AST_LOAD: assert property (clk_en && load && !soft_rst
      |=> s_q.live == $past(s_q.user) && s_q.hs == BRTC_IDLE && !rtc_busy)
    else $error("write release did not load calendar");
  AST_BUSY: assert property (clk_en && s_q.hs == BRTC_WOPEN && wr_rw && !pwdata[1]
      && !soft_rst |=> rtc_busy)
    else $error("busy missing during write transfer");
  AST_CENTURY: assert property (clk_en && tick && n_cent && !soft_rst
      |=> century_event && s_q.cent && s_q.live.year == 8'h00 ##1 !century_event)
    else $error("century event missing");
  AST_FREEZE: assert property (clk_en && s_q.hs == BRTC_RHOLD && !wr_rw && !soft_rst
      |=> $stable(s_q.user))
    else $error("frozen copy changed");

  COV_CENTURY: cover property (century_event);
  COV_LOAD: cover property (load);
  COV_READ: cover property (s_q.hs == BRTC_RCOPY ##1 s_q.hs == BRTC_RHOLD);
  COV_TRIM: cover property (tick && hour_end && s_q.trim_magnitude != 6'h00);
endmodule

/* hw/brtc_map.svh */
// register offsets, field positions, reset values and counts
`ifndef BRTC_MAP_SVH
`define BRTC_MAP_SVH
`define BRTC_OFF_CTRL   8'h00
`define BRTC_OFF_RESET  8'h04
`define BRTC_OFF_TRIM   8'h08
`define BRTC_OFF_RW     8'h0c
`define BRTC_OFF_STAT   8'h10
`define BRTC_OFF_TIME   8'h14
`define BRTC_OFF_DATE   8'h18
`define BRTC_CTRL_OSC   0
`define BRTC_CTRL_BYP   1
`define BRTC_CTRL_SRC   2
`define BRTC_CTRL_PRE   4
`define BRTC_RST_BIT    0
`define BRTC_TRIM_DIR   6
`define BRTC_RW_RD      0
`define BRTC_RW_WR      1
`define BRTC_STAT_BUSY  0
`define BRTC_STAT_CENT  1
`define BRTC_SEC_LSB    0
`define BRTC_MIN_LSB    8
`define BRTC_HOUR_LSB   16
`define BRTC_FMT_BIT    22
`define BRTC_DAY_LSB    24
`define BRTC_DATE_LSB   0
`define BRTC_MON_LSB    8
`define BRTC_YEAR_LSB   16
`define BRTC_TERM_32K   16'h8000
`define BRTC_TERM_60    16'h003c
`define BRTC_TERM_50    16'h0032
`define BRTC_TRIM_SHIFT 7
`define BRTC_RST_DATE   6'h01
`define BRTC_RST_MON    4'h1
`define BRTC_RST_DAY    3'h1
`endif

/* hw/brtc_pkg.sv */
// types of the backup-domain calendar clock
package brtc_pkg;
  typedef enum logic [1:0] {
    BRTC_PRE_32K = 2'h0,
    BRTC_PRE_60  = 2'h1,
    BRTC_PRE_50  = 2'h2
  } brtc_pre_t;
  typedef enum logic [2:0] {
    BRTC_IDLE  = 3'h0,
    BRTC_WOPEN = 3'h1,
    BRTC_WLOAD = 3'h3,
    BRTC_RCOPY = 3'h4,
    BRTC_RHOLD = 3'h6
  } brtc_hs_t;
  typedef struct packed {
    logic [6:0] seconds_field;
    logic [6:0] minutes;
    logic [5:0] hours;
    logic       hour_format_select;
    logic [2:0] weekday;
    logic [5:0] day_of_month;
    logic [3:0] month_field;
    logic [7:0] year;
  } brtc_cal_t;
  typedef struct packed {
    logic        osc_en;
    logic        bypass;
    logic        src;
    brtc_pre_t   pre;
    logic [5:0]  trim_magnitude;
    logic        trim_direction;
    brtc_hs_t    hs;
    logic        cent;
    logic        cent_pulse;
    logic        lf_prev;
    logic [15:0] div;
    brtc_cal_t   live;
    brtc_cal_t   user;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } brtc_st_t;
endpackage

/* hw/brtc_cal_step.sv */
// one-second advance of the bcd calendar, combinational
`timescale 1ns/1ps
module brtc_cal_step (
  // current calendar
  input  wire logic [6:0] sec,
  input  wire logic [6:0] min,
  input  wire logic [5:0] hour,
  input  wire logic       hour_format_select,
  input  wire logic [2:0] day,
  input  wire logic [5:0] date,
  input  wire logic [3:0] month_field,
  input  wire logic [7:0] year,
  // calendar one second later
  output logic      [6:0] sec_n,
  output logic      [6:0] min_n,
  output logic      [5:0] hour_n,
  output logic      [2:0] day_n,
  output logic      [5:0] date_n,
  output logic      [3:0] mon_n,
  output logic      [7:0] year_n,
  output logic            century
);
  import brtc_pkg::*;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  logic       leap;
  logic [5:0] mlen;
  logic [7:0] t_s;
  logic [7:0] t_m;
  logic [7:0] t_h;
  logic [7:0] t_d;
  logic [7:0] t_y;

  always_comb begin
    // divisible by four: even tens with 0/4/8, odd tens with 2/6
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month_field)
      4'h2: mlen = leap ? 6'h29 : 6'h28;
      4'h4, 4'h6, 4'h9, 4'hb: mlen = 6'h30;
      default: mlen = 6'h31;
    endcase
    t_s = bcd_inc({1'b0, sec});
    t_m = bcd_inc({1'b0, min});
    t_h = bcd_inc({2'h0, hour});
    t_d = bcd_inc({2'h0, date});
    t_y = bcd_inc(year);
    sec_n   = t_s[6:0];
    min_n   = min;
    hour_n  = hour;
    day_n   = day;
    date_n  = date;
    mon_n   = month_field;
    year_n  = year;
    century = 1'b0;
    if (sec == 7'h59) begin
      sec_n = 7'h00;
      min_n = t_m[6:0];
      if (min == 7'h59) begin
        min_n = 7'h00;
        hour_n = t_h[5:0];
        if (!hour_format_select) begin
          if (hour == 6'h23) hour_n = 6'h00;
        end else if (hour[4:0] == 5'h12) begin
          hour_n = {hour[5], 5'h01};
        end else if (hour[4:0] == 5'h11) begin
          hour_n = {~hour[5], 5'h12};
        end
        if (hour_format_select ? (hour == 6'h31) : (hour == 6'h23)) begin
          day_n  = (day == 3'h7) ? 3'h1 : day + 3'h1;
          date_n = t_d[5:0];
          if (date == mlen) begin
            date_n = 6'h01;
            mon_n  = month_field + 4'h1;
            if (month_field == 4'hc) begin
              mon_n  = 4'h1;
              year_n = t_y;
              if (year == 8'h99) begin
                year_n  = 8'h00;
                century = 1'b1;
              end
            end
          end
        end
      end
    end
  end
endmodule

/* tb/brtc_top_tb_top.sv */
// self-checking bench of the backup-domain calendar clock
`timescale 1ns/1ps
`include "brtc_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module brtc_top_tb_top;
  typedef struct {
    logic [31:0] t_in, d_in, t_exp, d_exp, st_exp;
  } brtc_row_t;
  logic        sys_clk    = 1'b0;
  logic        resetn     = 1'b0;
  logic        clk_en     = 1'b1;
  logic        xtal       = 1'b0;
  logic        alt        = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        watch_osc_enable;
  logic        osc_bypass_select;
  logic        rtc_busy;
  logic        century_event;
  logic [31:0] rdat;
  logic        rerr;
  logic        use_xtal   = 1'b0;
  int          term       = 50;
  int          n_cent     = 0;
  int          n_mismatch = 0;
  int          compares   = 0;
  // rollover cases: one tick from t_in/d_in
  brtc_row_t   rows[9]    = '{
    '{32'h07235959, 32'h00240228, 32'h01000000, 32'h00240229, 32'h0},
    '{32'h07235959, 32'h00230228, 32'h01000000, 32'h00230301, 32'h0},
    '{32'h03235959, 32'h00990c31, 32'h04000000, 32'h00000101, 32'h2},
    '{32'h02715959, 32'h00050430, 32'h03520000, 32'h00050501, 32'h0},
    '{32'h04515959, 32'h00050115, 32'h04720000, 32'h00050115, 32'h0},
    '{32'h04725959, 32'h00050115, 32'h04610000, 32'h00050115, 32'h0},
    '{32'h01095959, 32'h00230115, 32'h01100000, 32'h00230115, 32'h0},
    '{32'h05235959, 32'h00230930, 32'h06000000, 32'h00230a01, 32'h0},
    '{32'h01000009, 32'h00230115, 32'h01000010, 32'h00230115, 32'h0}};

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (century_event === 1'b1) n_cent <= n_cent + 1;

  brtc_top i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .watch_crystal_osc(xtal), .low_freq_system_clock(alt),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watch_osc_enable(watch_osc_enable), .osc_bypass_select(osc_bypass_select),
    .rtc_busy(rtc_busy), .century_event(century_event));

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        rdat = prdata; rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    summarize;
  endtask

  // rising edges on one timebase input, 2 system cycles each to keep long counts short
  task pulses(input int n, input logic x);
    repeat (n) begin
      @(posedge sys_clk);
      if (x) xtal <= 1'b1; else alt <= 1'b1;
      @(posedge sys_clk);
      xtal <= 1'b0; alt <= 1'b0;
    end
  endtask

  task wait_idle;
    for (int i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (rtc_busy === 1'b0) return;
    end
    n_mismatch++;
    summarize;
  endtask

  task set_cal(input logic [31:0] t, input logic [31:0] d);
    apb(1, `BRTC_OFF_RW, 32'h2); apb(1, `BRTC_OFF_TIME, t); apb(1, `BRTC_OFF_DATE, d);
    apb(1, `BRTC_OFF_RW, 32'h0);
    pulses(1, use_xtal);
    wait_idle;
  endtask

  task rd_cal(input logic [31:0] et, input logic [31:0] ed);
    apb(1, `BRTC_OFF_RW, 32'h1);
    wait_idle;
    apb(0, `BRTC_OFF_TIME, 0); `CHK(rdat, et)
    apb(0, `BRTC_OFF_DATE, 0); `CHK(rdat, ed)
    apb(1, `BRTC_OFF_RW, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 0); `CHK(rdat, 32'h0)
    end
    rd_cal(32'h01000000, 32'h00000101);
    apb(0, 8'h1c, 0); `CHK(rerr, 1'b1)
    apb(0, 8'h02, 0); `CHK(rerr, 1'b1)
    apb(1, `BRTC_OFF_CTRL, 32'h2); apb(1, `BRTC_OFF_CTRL, 32'h3);
    // control outputs settle only after the access edge
    @(negedge sys_clk);
    `CHK({watch_osc_enable, osc_bypass_select}, 2'b11)
    // alternate source, count 50; trim set but must stay unused
    apb(1, `BRTC_OFF_CTRL, 32'h24);
    apb(1, `BRTC_OFF_TRIM, 32'h7f);
    apb(0, `BRTC_OFF_TRIM, 0); `CHK(rdat, 32'h7f)
    foreach (rows[i]) begin
      set_cal(rows[i].t_in, rows[i].d_in);
      pulses(term, use_xtal);
      rd_cal(rows[i].t_exp, rows[i].d_exp);
      apb(0, `BRTC_OFF_STAT, 0); `CHK(rdat, rows[i].st_exp)
      apb(1, `BRTC_OFF_STAT, 32'h2);
    end
    `CHK(n_cent, 1)
    // user write with no write request is dropped
    apb(1, `BRTC_OFF_TIME, 32'h0);
    rd_cal(32'h01000010, 32'h00230115);
    // frozen copy while the read request stays open
    apb(1, `BRTC_OFF_RW, 32'h1);
    wait_idle;
    pulses(term, use_xtal);
    apb(0, `BRTC_OFF_TIME, 0); `CHK(rdat, 32'h01000010)
    apb(1, `BRTC_OFF_RW, 32'h0);
    rd_cal(32'h01000011, 32'h00230115);
    // request refusals and busy window
    apb(1, `BRTC_OFF_RW, 32'h2); apb(1, `BRTC_OFF_RW, 32'h3);
    apb(0, `BRTC_OFF_RW, 0); `CHK(rdat, 32'h2)
    apb(1, `BRTC_OFF_TIME, 32'h01000020);
    apb(1, `BRTC_OFF_RW, 32'h0);
    @(posedge sys_clk);
    `CHK(rtc_busy, 1'b1)
    apb(1, `BRTC_OFF_RW, 32'h1);
    apb(0, `BRTC_OFF_RW, 0); `CHK(rdat, 32'h0)
    apb(0, `BRTC_OFF_STAT, 0); `CHK(rdat, 32'h1)
    pulses(1, use_xtal);
    wait_idle;
    rd_cal(32'h01000020, 32'h00230115);
    apb(1, `BRTC_OFF_RW, 32'h1); apb(1, `BRTC_OFF_RW, 32'h3);
    apb(0, `BRTC_OFF_RW, 0); `CHK(rdat, 32'h1)
    apb(1, `BRTC_OFF_RW, 32'h0);
    // count 60: 120 edges give exactly two seconds
    apb(1, `BRTC_OFF_CTRL, 32'h14);
    term = 60;
    set_cal(32'h01000000, 32'h00230115);
    pulses(2 * term, use_xtal);
    rd_cal(32'h01000002, 32'h00230115);
    // soft reset returns control and calendar to reset values
    apb(1, `BRTC_OFF_RESET, 32'h1);
    apb(0, `BRTC_OFF_CTRL, 0); `CHK(rdat, 32'h0)
    rd_cal(32'h01000000, 32'h00000101);
    // crystal source: alternate edges must not count
    apb(1, `BRTC_OFF_CTRL, 32'h21);
    term = 50;
    use_xtal = 1'b1;
    pulses(term, 1'b0);
    rd_cal(32'h01000000, 32'h00000101);
    pulses(term, 1'b1);
    rd_cal(32'h01000001, 32'h00000101);
    // clock enable low: timebase edges must be lost, calendar frozen
    clk_en <= 1'b0;
    pulses(term, 1'b1);
    clk_en <= 1'b1;
    rd_cal(32'h01000001, 32'h00000101);
    // count 32768 with full add trim on the 59:59 second: 32768 - 63 * 128 edges
    apb(1, `BRTC_OFF_CTRL, 32'h1);
    apb(1, `BRTC_OFF_TRIM, 32'h7f);
    set_cal(32'h01005959, 32'h00000101);
    pulses(24703, 1'b1);
    rd_cal(32'h01005959, 32'h00000101);
    pulses(1, 1'b1);
    rd_cal(32'h01010000, 32'h00000101);
    // cold start in mid-run
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    `CHK({pready, watch_osc_enable, rtc_busy}, 3'b000)
    resetn <= 1'b1;
    apb(0, `BRTC_OFF_CTRL, 0); `CHK(rdat, 32'h0)
    summarize;
  end
endmodule
